// ---- src/blpr_pkg.sv ----
// shared constants for the bus lane, parity and ratio block
package blpr_pkg;
   localparam int BLPR_ADDR_HI = 31;
   localparam int BLPR_ADDR_LO = 5;
   localparam int BLPR_ADDR_W = BLPR_ADDR_HI - BLPR_ADDR_LO + 1;
   localparam int BLPR_LANES = 8;
   localparam int BLPR_LANE_BITS = 8;
   localparam int BLPR_SEL_W = 3;
   localparam int BLPR_RATIO_W = 4;
   // ratio in half steps: multiplier times two
   localparam logic [2:0] BLPR_SEL_2P5 = 3'h4;
   localparam logic [2:0] BLPR_SEL_3P0 = 3'h5;
   localparam logic [2:0] BLPR_SEL_3P5 = 3'h7;
   localparam logic [2:0] BLPR_SEL_4P0 = 3'h2;
   localparam logic [2:0] BLPR_SEL_4P5 = 3'h0;
   localparam logic [2:0] BLPR_SEL_5P0 = 3'h1;
   localparam logic [2:0] BLPR_SEL_5P5 = 3'h3;
   localparam logic [2:0] BLPR_SEL_6P0 = 3'h6;
   localparam logic [3:0] BLPR_HALF_2P5 = 4'h5;
   localparam logic [3:0] BLPR_HALF_3P0 = 4'h6;
   localparam logic [3:0] BLPR_HALF_3P5 = 4'h7;
   localparam logic [3:0] BLPR_HALF_4P0 = 4'h8;
   localparam logic [3:0] BLPR_HALF_4P5 = 4'h9;
   localparam logic [3:0] BLPR_HALF_5P0 = 4'ha;
   localparam logic [3:0] BLPR_HALF_5P5 = 4'hb;
   localparam logic [3:0] BLPR_HALF_6P0 = 4'hc;
   localparam logic [2:0] BLPR_SEL_RST = 3'h7;
   localparam logic [7:0] BLPR_LANE_IDLE = 8'hff;
endpackage : blpr_pkg

// ---- src/blpr_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module blpr_sync
   import blpr_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule : blpr_sync

// ---- src/blpr_ctrl.sv ----
// lane select drive, snoop address parity check and core ratio strap latch
`timescale 1ns/1ns
module blpr_ctrl
   import blpr_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic snoop_valid,
   input wire logic [BLPR_ADDR_W-1:0] snoop_addr,
   input wire logic addr_parity_bit,
   input wire logic cyc_start,
   input wire logic cyc_write,
   input wire logic cyc_special,
   input wire logic [BLPR_LANES-1:0] cyc_bytes,
   input wire logic [BLPR_LANES-1:0] cyc_special_code,
   input wire logic cyc_end,
   input wire logic [BLPR_SEL_W-1:0] core_ratio_sel,
   output logic [BLPR_LANES-1:0] lane_select_n,
   output logic [BLPR_LANES-1:0] lane_write_n,
   output logic addr_parity_fail_n,
   output logic [BLPR_RATIO_W-1:0] core_ratio_half,
   output logic ratio_locked
);

   ////////////////////////////////////////////////////////////////////////////
   // ratio decode
   function automatic logic [BLPR_RATIO_W-1:0] blpr_ratio(input logic [2:0] sel);
      logic [BLPR_RATIO_W-1:0] r;
      r = BLPR_HALF_3P5;
      case (sel)
         BLPR_SEL_2P5: r = BLPR_HALF_2P5;
         BLPR_SEL_3P0: r = BLPR_HALF_3P0;
         BLPR_SEL_3P5: r = BLPR_HALF_3P5;
         BLPR_SEL_4P0: r = BLPR_HALF_4P0;
         BLPR_SEL_4P5: r = BLPR_HALF_4P5;
         BLPR_SEL_5P0: r = BLPR_HALF_5P0;
         BLPR_SEL_5P5: r = BLPR_HALF_5P5;
         BLPR_SEL_6P0: r = BLPR_HALF_6P0;
         default: r = BLPR_HALF_3P5;
      endcase
      return r;
   endfunction : blpr_ratio

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [BLPR_SEL_W-1:0] sel_s;
   logic snoop_valid_s;
   logic [BLPR_ADDR_W-1:0] snoop_addr_s;
   logic parity_s;

   blpr_sync #(.WIDTH(BLPR_SEL_W), .RST_VAL(BLPR_SEL_RST)) u_sel_sync
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din(core_ratio_sel),
      .dout(sel_s)
   );

   blpr_sync #(.WIDTH(BLPR_ADDR_W + 2)) u_snoop_sync
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din({snoop_valid, addr_parity_bit, snoop_addr}),
      .dout({snoop_valid_s, parity_s, snoop_addr_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // ratio strap latch
   logic [1:0] rst_seen_q;
   logic [1:0] rst_seen_d;
   logic [BLPR_RATIO_W-1:0] ratio_q;
   logic [BLPR_RATIO_W-1:0] ratio_d;
   logic locked_q;
   logic locked_d;

   always_comb
   begin
      rst_seen_d = {rst_seen_q[0], 1'b1};
      ratio_d = ratio_q;
      locked_d = locked_q;
      // third clock after release: the synchroniser then holds the pin, not its reset value
      if (!locked_q && rst_seen_q[1])
      begin
         ratio_d = blpr_ratio(sel_s);
         locked_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rst_seen_q <= 2'h0;
         ratio_q <= BLPR_HALF_3P5;
         locked_q <= 1'b0;
      end
      else
      begin
         rst_seen_q <= rst_seen_d;
         ratio_q <= ratio_d;
         locked_q <= locked_d;
      end
   end

   assign core_ratio_half = ratio_q;
   assign ratio_locked = locked_q;

   ////////////////////////////////////////////////////////////////////////////
   // snoop parity check
   logic fail_n_q;
   logic fail_n_d;

   always_comb
   begin
      fail_n_d = 1'b1;
      // even parity over bit and address 31..5 only
      if (snoop_valid_s && ((^snoop_addr_s) ^ parity_s))
      begin
         fail_n_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fail_n_q <= 1'b1;
      end
      else
      begin
         fail_n_q <= fail_n_d;
      end
   end

   assign addr_parity_fail_n = fail_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // lane select state machine
   typedef enum logic [2:0]
   {
      BLPR_IDLE = 3'h1,
      BLPR_DATA = 3'h2,
      BLPR_SPEC = 3'h4
   } blpr_state_t;

   blpr_state_t state_q;
   blpr_state_t state_d;
   logic [BLPR_LANES-1:0] lane_q;
   logic [BLPR_LANES-1:0] lane_d;
   logic [BLPR_LANES-1:0] wr_q;
   logic [BLPR_LANES-1:0] wr_d;

   always_comb
   begin
      state_d = state_q;
      lane_d = lane_q;
      wr_d = wr_q;
      case (state_q)
         BLPR_IDLE:
         begin
            if (cyc_start && cyc_special)
            begin
               state_d = BLPR_SPEC;
               lane_d = cyc_special_code;
               wr_d = BLPR_LANE_IDLE;
            end
            else if (cyc_start)
            begin
               state_d = BLPR_DATA;
               lane_d = ~cyc_bytes;
               wr_d = cyc_write ? ~cyc_bytes : BLPR_LANE_IDLE;
            end
         end
         BLPR_DATA, BLPR_SPEC:
         begin
            if (cyc_end)
            begin
               state_d = BLPR_IDLE;
               lane_d = BLPR_LANE_IDLE;
               wr_d = BLPR_LANE_IDLE;
            end
         end
         default:
         begin
            state_d = BLPR_IDLE;
            lane_d = BLPR_LANE_IDLE;
            wr_d = BLPR_LANE_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= BLPR_IDLE;
         lane_q <= BLPR_LANE_IDLE;
         wr_q <= BLPR_LANE_IDLE;
      end
      else
      begin
         state_q <= state_d;
         lane_q <= lane_d;
         wr_q <= wr_d;
      end
   end

   // bit n of each lane vector governs data bits 8n+7..8n
   genvar gi;
   generate
      for (gi = 0; gi < BLPR_LANES; gi++)
      begin : g_lane
         assign lane_select_n[gi] = lane_q[gi];
         assign lane_write_n[gi] = wr_q[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   AST_FAIL_ONE_CLK: assert property (@(posedge mclk) disable iff (sys_rst)
      (snoop_valid_s && ((^snoop_addr_s) ^ parity_s)) |=> !addr_parity_fail_n)
      else $error("parity fail not asserted after mismatch");
   AST_NO_FALSE_FAIL: assert property (@(posedge mclk) disable iff (sys_rst)
      !(snoop_valid_s && ((^snoop_addr_s) ^ parity_s)) |=> addr_parity_fail_n)
      else $error("parity fail without mismatch");
   AST_SAMPLE_ADDR: assert property (@(posedge mclk) disable iff (sys_rst)
      (!addr_parity_fail_n) |-> $past(snoop_valid, 3) &&
      ($past(addr_parity_bit, 3) ^ (^$past(snoop_addr, 3))))
      else $error("parity fail outside snoop sample");
   AST_LANE_REQ: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == BLPR_IDLE && cyc_start && !cyc_special) |=>
      (lane_select_n == ~$past(cyc_bytes)) && state_q == BLPR_DATA)
      else $error("lane select does not match requested bytes");
   AST_WRITE_LANES: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == BLPR_DATA) |-> (lane_write_n == lane_select_n || lane_write_n == 8'hff))
      else $error("write lanes disagree with lane select");
   AST_SPECIAL: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == BLPR_IDLE && cyc_start && cyc_special) |=>
      (lane_select_n == $past(cyc_special_code)) && (lane_write_n == 8'hff))
      else $error("special cycle pattern not driven");
   AST_IDLE_LANES: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == BLPR_IDLE) |-> lane_select_n == 8'hff)
      else $error("lanes active while idle");
   AST_RATIO_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      locked_q |-> (core_ratio_half >= 4'h5 && core_ratio_half <= 4'hc))
      else $error("ratio out of range");
   AST_RATIO_DEFAULT: assert property (@(posedge mclk) disable iff (sys_rst)
      ($rose(locked_q) && $past(sel_s) == 3'h7) |-> core_ratio_half == 4'h7)
      else $error("all-high strap not 3.5");
   AST_RATIO_HIGH: assert property (@(posedge mclk) disable iff (sys_rst)
      ($rose(locked_q) && $past(sel_s) == 3'h6) |-> core_ratio_half == 4'hc)
      else $error("strap 110 not 6.0");
   AST_RATIO_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      $past(locked_q) |-> $stable(core_ratio_half) && locked_q)
      else $error("ratio changed after lock");

   COV_PARITY_FAIL: cover property (@(posedge mclk) disable iff (sys_rst)
      $fell(addr_parity_fail_n));
   COV_WRITE: cover property (@(posedge mclk) disable iff (sys_rst)
      state_q == BLPR_DATA && lane_write_n != 8'hff);
   COV_SPECIAL: cover property (@(posedge mclk) disable iff (sys_rst)
      state_q == BLPR_SPEC);
   COV_LOCK: cover property (@(posedge mclk) disable iff (sys_rst) $rose(locked_q));
endmodule : blpr_ctrl

// ---- test/blpr_sys_model.sv ----
// chipset-side model: snoop address, parity pin and ratio straps
`timescale 1ns/1ns
module blpr_sys_model
   import blpr_pkg::*;
(
   input wire logic mclk,
   input wire logic snp_go,
   input wire logic snp_bad,
   input wire logic [BLPR_ADDR_W-1:0] snp_a,
   input wire logic strap_drive,
   input wire logic [BLPR_SEL_W-1:0] strap_val,
   output logic snoop_valid,
   output logic [BLPR_ADDR_W-1:0] snoop_addr,
   output logic addr_parity_bit,
   output logic [BLPR_SEL_W-1:0] core_ratio_sel
);
   // undriven straps settle at the pulled-up level
   assign core_ratio_sel = strap_drive ? strap_val : 3'h7;
   initial
   begin
      snoop_valid = 1'b0;
      snoop_addr = '0;
      addr_parity_bit = 1'b0;
   end
   always @(posedge mclk)
   begin
      #2;
      snoop_valid = snp_go;
      if (snp_go)
      begin
         snoop_addr = snp_a;
         addr_parity_bit = (^snp_a) ^ snp_bad;
      end
      else
      begin
         // released bus: show a changing pattern, not the last value
         snoop_addr = ~snoop_addr;
         addr_parity_bit = ~addr_parity_bit;
      end
   end
endmodule : blpr_sys_model

// ---- test/tb_top.sv ----
// self-checking bench for the lane, parity and ratio block
`timescale 1ns/1ns
module tb_top;
   import blpr_pkg::*;
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
   $display("Error %s exp %h got %h", nm, ex, got); end end
   logic mclk, sys_rst, snp_go, snp_bad, strap_drive;
   logic [26:0] snp_a;
   logic [2:0] strap_val;
   logic snoop_valid, addr_parity_bit, cyc_start, cyc_write, cyc_special, cyc_end;
   logic [26:0] snoop_addr;
   logic [2:0] core_ratio_sel;
   logic [7:0] cyc_bytes, cyc_special_code, lane_select_n, lane_write_n;
   logic addr_parity_fail_n, ratio_locked;
   logic [3:0] core_ratio_half;
   int error_cnt = 0;
   int n_tests = 0;
   blpr_sys_model i_blpr_sys_model (.mclk(mclk), .snp_go(snp_go), .snp_bad(snp_bad),
      .snp_a(snp_a), .strap_drive(strap_drive), .strap_val(strap_val),
      .snoop_valid(snoop_valid), .snoop_addr(snoop_addr),
      .addr_parity_bit(addr_parity_bit), .core_ratio_sel(core_ratio_sel));
   blpr_ctrl i_blpr_ctrl (.mclk(mclk), .sys_rst(sys_rst), .snoop_valid(snoop_valid),
      .snoop_addr(snoop_addr), .addr_parity_bit(addr_parity_bit), .cyc_start(cyc_start),
      .cyc_write(cyc_write), .cyc_special(cyc_special), .cyc_bytes(cyc_bytes),
      .cyc_special_code(cyc_special_code), .cyc_end(cyc_end),
      .core_ratio_sel(core_ratio_sel), .lane_select_n(lane_select_n),
      .lane_write_n(lane_write_n), .addr_parity_fail_n(addr_parity_fail_n),
      .core_ratio_half(core_ratio_half), .ratio_locked(ratio_locked));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic do_reset(input logic [2:0] sel, input logic drv);
      strap_drive = drv;
      strap_val = sel;
      sys_rst = 1'b1;
      tick(2);
      `CHK("unlocked", 1'b0, ratio_locked)
      sys_rst = 1'b0;
      tick(3);
   endtask : do_reset
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ratio;
      logic [2:0] codes [8];
      logic [3:0] halves [8];
      codes = '{3'h4, 3'h5, 3'h7, 3'h2, 3'h0, 3'h1, 3'h3, 3'h6};
      halves = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
      for (int i = 0; i < 8; i++)
      begin
         do_reset(codes[i], 1'b1);
         `CHK("ratio", halves[i], core_ratio_half)
         `CHK("locked", 1'b1, ratio_locked)
      end
      strap_val = 3'h4;
      tick(4);
      `CHK("ratio held", 4'hc, core_ratio_half)
      do_reset(3'h0, 1'b0);
      `CHK("ratio open", 4'h7, core_ratio_half)
   endtask : t_ratio
   // hold a snoop sample for n cycles and follow the fail pin for n+3 edges
   task automatic snoop(input logic [26:0] a, input logic bad, input int n);
      logic ex;
      snp_a = a;
      snp_bad = bad;
      snp_go = 1'b1;
      for (int k = 1; k <= n + 3; k++)
      begin
         tick(1);
         if (k == n)
            snp_go = 1'b0;
         ex = (bad && k >= 3 && k <= n + 2) ? 1'b0 : 1'b1;
         `CHK("fail_n", ex, addr_parity_fail_n)
      end
   endtask : snoop
   task automatic bus(input logic wr, input logic sp, input logic [7:0] by,
      input logic [7:0] code, input logic [7:0] ex_l, input logic [7:0] ex_w);
      cyc_write = wr;
      cyc_special = sp;
      cyc_bytes = by;
      cyc_special_code = code;
      cyc_start = 1'b1;
      tick(1);
      cyc_start = 1'b0;
      `CHK("lanes", ex_l, lane_select_n)
      `CHK("wlanes", ex_w, lane_write_n)
      cyc_bytes = ~by;
      cyc_special_code = ~code;
      cyc_start = 1'b1;
      tick(1);
      cyc_start = 1'b0;
      tick(1);
      `CHK("lanes busy", ex_l, lane_select_n)
      cyc_end = 1'b1;
      tick(1);
      cyc_end = 1'b0;
      `CHK("lanes idle", 8'hff, lane_select_n)
      `CHK("wlanes idle", 8'hff, lane_write_n)
   endtask : bus
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst = 1'b1;
      snp_go = 1'b0;
      snp_bad = 1'b0;
      snp_a = '0;
      strap_drive = 1'b1;
      strap_val = 3'h5;
      cyc_start = 1'b0;
      cyc_write = 1'b0;
      cyc_special = 1'b0;
      cyc_end = 1'b0;
      cyc_bytes = 8'h00;
      cyc_special_code = 8'hff;
      repeat (12) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      tick(3);
      `CHK("ratio first", 4'h6, core_ratio_half)
      bus(1'b1, 1'b0, 8'h0f, 8'hff, 8'hf0, 8'hf0);
      bus(1'b0, 1'b0, 8'h80, 8'hff, 8'h7f, 8'hff);
      bus(1'b1, 1'b0, 8'h01, 8'hff, 8'hfe, 8'hfe);
      bus(1'b0, 1'b1, 8'h00, 8'h7b, 8'h7b, 8'hff);
      snoop(27'h5a5a5a5, 1'b0, 1);
      snoop(27'h0000001, 1'b1, 1);
      snoop(27'h7ffffff, 1'b1, 2);
      snoop(27'h4000000, 1'b0, 2);
      t_ratio();
      test_done();
   end
   initial
   begin
      #(2000 * 100);
      error_cnt++;
      test_done();
   end
endmodule : tb_top
